// ---- rtl/fipi_regs.svh ----
// Instruction field codes, status field positions and queue sizing
`ifndef FIPI_REGS_SVH
`define FIPI_REGS_SVH
`define FIPI_OP_MEM 2'h3
`define FIPI_OP_ALU 2'h2
`define FIPI_OP3_LD 6'h20
`define FIPI_OP3_LOAD_STATUS_OP 6'h21
`define FIPI_OP3_LDD 6'h23
`define FIPI_OP3_ST 6'h24
`define FIPI_OP3_STORE_STATUS_OP 6'h25
`define FIPI_OP3_STQ 6'h26
`define FIPI_OP3_STD 6'h27
`define FIPI_OP3_FPOP1 6'h34
`define FIPI_OP3_FPOP2 6'h35
`define FIPI_OPF_CMP_HI 5'h05
`define FIPI_OPF_CMP_QUAD 2'h3
`define FIPI_FCC_LSB 10
`define FIPI_QDEPTH 4
`endif

// ---- rtl/fipi_pkg.sv ----
// Types shared by the issue pipeline interface
`default_nettype none
package fipi_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] instr;
  } fipi_entry_type;
  typedef struct packed {
    logic fetch;
    logic stall_a_n;
    logic stall_b_n;
    logic stall_bus_n;
    logic stall_cp_n;
    logic ccv;
    logic strobe_n;
    logic abort;
    logic slot1;
    logic slot2;
    logic [31:0] addr;
    logic [31:0] data;
  } fipi_pins_type;
  typedef enum logic [3:0] {
    CL_NONE, CL_LD, CL_LDD, CL_LOAD_STATUS_OP, CL_ST, CL_STD, CL_STORE_STATUS_OP, CL_STQ, CL_FP_OPERATE_OP, CL_CMP
  } fipi_class_type;
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_WR, ST_WH1, ST_WH2, ST_CMPW, ST_CMPV
  } fipi_state_type;
endpackage : fipi_pkg
`default_nettype wire

// ---- rtl/fipi_core.sv ----
// Issue pipeline interface of the floating-point coprocessor
// Notes on behaviour
// - Latch address one cycle before its word
// - Fetch flag qualifies word and previous address
// - Cache miss: replace captured word later
// - Reload in hold only after fetch
// - Launch strobe starts selected buffer entry
// - Ignore launches under abort, stall, invalid
// - Compare drops condition-valid in write
// - Codes valid one cycle before valid
// - Unimplemented compare freezes and traps
// - Operation queued after first write cycle
// - Completed operation leaves queue head
// - Aborted load leaves registers untouched
// - Aborted store releases data bus quickly
// - Aborted operation changes nothing, queue continues
// - Aborted compare restores valid next cycle
// - Any stall or invalid freezes pipelines
// - Stalls freeze memory ops, not queue
// - Load data capture and write timing
// - Store data drive and release timing
// - Full queue stalls entering execute
`default_nettype none
`include "fipi_regs.svh"
module fipi_core #(
  parameter int QDEPTH = `FIPI_QDEPTH,
  parameter int CW = $clog2(QDEPTH + 1)
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic [31:0] addr_bus, // Shared address bus
  input wire logic [31:0] data_in, // Shared data bus, input side
  output logic [31:0] data_out, // Shared data bus, output side
  output logic data_oe, // High while driving data bus
  input wire logic instr_fetch_flag, // Fetch marker from integer unit
  input wire logic mem_stall_a_n, // Memory stall A, low active
  input wire logic mem_stall_b_n, // Memory stall B, low active
  input wire logic bus_stall_n, // Bus stall, low active
  input wire logic cp_stall_n, // Coprocessor stall, low active
  input wire logic cp_cond_valid, // Coprocessor codes valid
  input wire logic mem_data_strobe_n, // Memory data strobe, low active
  input wire logic pipeline_abort, // Abort from integer unit
  input wire logic launch_slot_one, // Launch newer buffer entry
  input wire logic launch_slot_two, // Launch older buffer entry
  input wire logic [63:0] store_src, // Register file read data
  input wire logic exec_done, // Queue head finished and written
  input wire logic cmp_done, // Compare result ready
  input wire logic [1:0] cmp_codes, // Compare result codes
  output logic fpu_stall_n, // Pipeline stall, low active
  output logic fp_cond_valid, // Condition codes valid
  output logic [1:0] fp_cond_codes, // Condition codes
  output logic unimpl_trap, // Unimplemented operation trap
  output fipi_pkg::fipi_entry_type issue_entry, // Entry sent to execution
  output logic issue_valid, // Pulse with issue_entry
  output logic [CW-1:0] queue_count, // Entries in execution queue
  output logic freg_we, // Register file write pulse
  output logic freg_double, // Write covers register pair
  output logic [4:0] freg_addr, // Register file address
  output logic [63:0] freg_wdata, // Upper word high, lower low
  output logic [31:0] fp_status // Status register
);
  import fipi_pkg::*;
  localparam int PW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
  // Two-stage synchronisers on every pin; the first stage feeds only the second
  fipi_pins_type pin_s1_reg, pin_s2_reg, p, pins;
  assign pins = '{fetch: instr_fetch_flag, stall_a_n: mem_stall_a_n, stall_b_n: mem_stall_b_n,
    stall_bus_n: bus_stall_n, stall_cp_n: cp_stall_n, ccv: cp_cond_valid, strobe_n: mem_data_strobe_n,
    abort: pipeline_abort, slot1: launch_slot_one, slot2: launch_slot_two, addr: addr_bus, data: data_in};
  always_ff @(posedge clock) begin
    pin_s1_reg <= pins;
    pin_s2_reg <= pin_s1_reg;
  end
  assign p = pin_s2_reg;
  // Freeze conditions
  wire ext_hold = ~p.stall_a_n | ~p.stall_b_n | ~p.stall_bus_n | ~p.stall_cp_n | ~p.ccv;
  wire hold = ext_hold | ~fpu_stall_n | ~fp_cond_valid;
  wire launch = (p.slot1 | p.slot2) & ~p.abort & ~hold;
  // Two-entry fetch buffer; slot1 newest
  logic [31:0] addr_prev_reg;
  logic fetch_last_reg;
  fipi_entry_type slot1_reg, slot2_reg, sel;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_prev_reg <= 32'h0;
      fetch_last_reg <= 1'b0;
      slot1_reg <= '0;
      slot2_reg <= '0;
    end else if (!hold) begin
      addr_prev_reg <= p.addr;
      fetch_last_reg <= p.fetch;
      if (p.fetch) begin
        slot2_reg <= slot1_reg;
        slot1_reg <= '{addr: addr_prev_reg, instr: p.data};
      end
    end else if (!p.strobe_n && fetch_last_reg) begin
      slot1_reg.instr <= p.data;
    end
  end
  // Older entry on the second strobe, newer on the first
  assign sel = p.slot2 ? slot2_reg : slot1_reg;
  // Decode of the selected instruction
  wire [1:0] sel_op = sel.instr[31:30];
  wire [5:0] sel_op3 = sel.instr[24:19];
  wire sel_mem = sel_op == `FIPI_OP_MEM;
  wire sel_alu = sel_op == `FIPI_OP_ALU;
  wire sel_cmp = sel_alu && sel_op3 == `FIPI_OP3_FPOP2 && sel.instr[13:9] == `FIPI_OPF_CMP_HI;
  fipi_class_type sel_cls;
  assign sel_cls = sel_cmp ? CL_CMP :
    (sel_alu && (sel_op3 == `FIPI_OP3_FPOP1 || sel_op3 == `FIPI_OP3_FPOP2)) ? CL_FP_OPERATE_OP :
    (sel_mem && sel_op3 == `FIPI_OP3_LD) ? CL_LD :
    (sel_mem && sel_op3 == `FIPI_OP3_LDD) ? CL_LDD :
    (sel_mem && sel_op3 == `FIPI_OP3_LOAD_STATUS_OP) ? CL_LOAD_STATUS_OP :
    (sel_mem && sel_op3 == `FIPI_OP3_ST) ? CL_ST :
    (sel_mem && sel_op3 == `FIPI_OP3_STD) ? CL_STD :
    (sel_mem && sel_op3 == `FIPI_OP3_STORE_STATUS_OP) ? CL_STORE_STATUS_OP :
    (sel_mem && sel_op3 == `FIPI_OP3_STQ) ? CL_STQ : CL_NONE;
  // Execution queue; entries retire in order from the head
  fipi_entry_type q_mem [QDEPTH];
  fipi_entry_type cur_reg;
  logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic push;
  wire q_full = queue_count == CW'(QDEPTH);
  wire pop = exec_done && queue_count != '0;
  fipi_entry_type q_head;
  assign q_head = q_mem[rd_ptr_reg];
  always_ff @(posedge clock) begin
    if (push) begin
      q_mem[wr_ptr_reg] <= cur_reg;
    end
  end
  // Queue pointers run regardless of freezes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      queue_count <= '0;
    end else begin
      wr_ptr_reg <= push ? PW'((wr_ptr_reg + 1'b1) % QDEPTH) : wr_ptr_reg;
      rd_ptr_reg <= pop ? PW'((rd_ptr_reg + 1'b1) % QDEPTH) : rd_ptr_reg;
      queue_count <= CW'(queue_count + CW'(push) - CW'(pop));
    end
  end
  // Instruction stage tracking
  fipi_state_type st_reg, st_next;
  fipi_class_type cls_reg;
  logic stall_next, fcv_next, oe_next, we_next, trap_next, issue_next, dbl_next;
  logic [31:0] dout_next, hi_reg, hi_next, fsr_next;
  logic [63:0] wdata_next;
  logic [1:0] codes_next;
  wire is_store = cls_reg inside {CL_ST, CL_STD, CL_STORE_STATUS_OP, CL_STQ};
  wire cmp_unimpl = cur_reg.instr[6:5] == `FIPI_OPF_CMP_QUAD;
  wire exec_go = !ext_hold && fp_cond_valid && fpu_stall_n && !(cls_reg == CL_FP_OPERATE_OP && q_full);
  always_comb begin
    st_next = st_reg;
    stall_next = 1'b1;
    fcv_next = fp_cond_valid;
    oe_next = data_oe;
    dout_next = data_out;
    push = 1'b0;
    issue_next = 1'b0;
    we_next = 1'b0;
    dbl_next = freg_double;
    wdata_next = freg_wdata;
    fsr_next = fp_status;
    trap_next = unimpl_trap;
    codes_next = fp_cond_codes;
    hi_next = hi_reg;
    case (st_reg)
      ST_IDLE: begin
        if (launch) begin
          st_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (p.abort) begin
          st_next = ST_IDLE;
        end else if (cls_reg == CL_FP_OPERATE_OP && q_full) begin
          stall_next = 1'b0;
        end else if (exec_go) begin
          st_next = (cls_reg == CL_CMP) ? ST_CMPW : ST_WR;
          if (cls_reg == CL_CMP) begin
            fcv_next = 1'b0;
            issue_next = 1'b1;
          end
          if (is_store) begin
            oe_next = 1'b1;
            dout_next = (cls_reg == CL_STORE_STATUS_OP) ? fp_status :
              (cls_reg == CL_STQ) ? q_head.addr : store_src[63:32];
          end
        end
      end
      ST_WR: begin
        if (p.abort) begin
          st_next = ST_IDLE;
          oe_next = 1'b0;
        end else if (cls_reg == CL_FP_OPERATE_OP) begin
          push = 1'b1;
          issue_next = 1'b1;
          st_next = ST_IDLE;
        end else if (!hold) begin
          hi_next = p.data;
          st_next = (cls_reg == CL_NONE) ? ST_IDLE : ST_WH1;
          if (cls_reg == CL_ST || cls_reg == CL_STORE_STATUS_OP) begin
            oe_next = 1'b0;
          end else if (cls_reg == CL_STQ) begin
            dout_next = q_head.instr;
          end else if (cls_reg == CL_STD) begin
            dout_next = store_src[31:0];
          end
        end
      end
      ST_WH1: begin
        if (p.abort) begin
          st_next = ST_IDLE;
          oe_next = 1'b0;
        end else if (!hold) begin
          st_next = (cls_reg == CL_LDD || cls_reg == CL_STD || cls_reg == CL_STQ) ? ST_WH2 : ST_IDLE;
          oe_next = 1'b0;
          if (cls_reg == CL_LD) begin
            we_next = 1'b1;
            dbl_next = 1'b0;
            wdata_next = {32'h0, hi_reg};
          end else if (cls_reg == CL_LOAD_STATUS_OP) begin
            fsr_next = hi_reg;
          end else if (cls_reg == CL_LDD) begin
            wdata_next = {hi_reg, p.data};
          end
        end
      end
      ST_WH2: begin
        if (p.abort) begin
          st_next = ST_IDLE;
        end else if (!hold) begin
          st_next = ST_IDLE;
          if (cls_reg == CL_LDD) begin
            we_next = 1'b1;
            dbl_next = 1'b1;
          end
        end
      end
      ST_CMPW: begin
        if (p.abort) begin
          st_next = ST_IDLE;
          fcv_next = 1'b1;
          trap_next = 1'b0;
        end else if (cmp_unimpl) begin
          trap_next = 1'b1;
        end else if (cmp_done) begin
          codes_next = cmp_codes;
          fsr_next[`FIPI_FCC_LSB+:2] = cmp_codes;
          st_next = ST_CMPV;
        end
      end
      ST_CMPV: begin
        fcv_next = 1'b1;
        st_next = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
  end
  // Stage and output registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= ST_IDLE;
      cls_reg <= CL_NONE;
      cur_reg <= '0;
      fpu_stall_n <= 1'b1;
      fp_cond_valid <= 1'b1;
      fp_cond_codes <= 2'h0;
      unimpl_trap <= 1'b0;
      data_oe <= 1'b0;
      data_out <= 32'h0;
      hi_reg <= 32'h0;
      freg_we <= 1'b0;
      freg_double <= 1'b0;
      freg_addr <= 5'h0;
      freg_wdata <= 64'h0;
      fp_status <= 32'h0;
      issue_entry <= '0;
      issue_valid <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (st_reg == ST_IDLE && launch) begin
        cur_reg <= sel;
        cls_reg <= sel_cls;
        freg_addr <= sel.instr[29:25];
      end
      fpu_stall_n <= stall_next;
      fp_cond_valid <= fcv_next;
      fp_cond_codes <= codes_next;
      unimpl_trap <= trap_next;
      data_oe <= oe_next;
      data_out <= dout_next;
      hi_reg <= hi_next;
      freg_we <= we_next;
      freg_double <= dbl_next;
      freg_wdata <= wdata_next;
      fp_status <= fsr_next;
      issue_entry <= issue_next ? cur_reg : issue_entry;
      issue_valid <= issue_next;
    end
  end
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_launch_ignored: assert property ((st_reg == ST_IDLE && (p.abort || hold)) |=> st_reg == ST_IDLE)
    else $error("launch taken while blocked");
  a_fetch_pair: assert property ((!hold && p.fetch) |=> (slot1_reg.addr == $past(addr_prev_reg)
    && slot1_reg.instr == $past(p.data)))
    else $error("fetch pair mismatch");
  a_cmp_valid_drop: assert property ((st_reg == ST_EXEC && st_next == ST_CMPW) |=> !fp_cond_valid)
    else $error("valid not dropped for compare");
  a_codes_lead: assert property (st_reg == ST_CMPV |-> !fp_cond_valid ##1 (fp_cond_valid
    && $stable(fp_cond_codes)))
    else $error("codes not ahead of valid");
  a_trap_freeze: assert property (unimpl_trap |-> !fp_cond_valid)
    else $error("trap without freeze");
  a_fp_operate_op_queued: assert property ((st_reg == ST_WR && cls_reg == CL_FP_OPERATE_OP && !p.abort) |=> issue_valid)
    else $error("operation not queued");
  a_abort_store: assert property ((st_reg inside {ST_WR, ST_WH1, ST_WH2} && p.abort) |=> !data_oe)
    else $error("bus held after abort");
  a_abort_load: assert property ((st_reg != ST_IDLE && p.abort) |=> !freg_we ##1 !freg_we)
    else $error("write after abort");
  a_cmp_abort: assert property ((st_reg == ST_CMPW && p.abort) |=> fp_cond_valid)
    else $error("valid not restored");
  a_queue_stall: assert property ((st_reg == ST_EXEC && cls_reg == CL_FP_OPERATE_OP && q_full && !p.abort)
    |=> !fpu_stall_n)
    else $error("full queue not stalled");
  a_double_load: assert property ((st_reg == ST_WH2 && cls_reg == CL_LDD && !hold && !p.abort)
    |=> freg_we && freg_double)
    else $error("double load not written");
  c_launch: cover property (st_reg == ST_IDLE && launch);
  c_cmp_done: cover property (st_reg == ST_CMPV ##1 fp_cond_valid);
  c_store_abort: cover property (st_reg == ST_WH1 && is_store && p.abort);
  c_queue_full: cover property (q_full && !fpu_stall_n);
endmodule : fipi_core
`default_nettype wire

// ---- verification/fipi_far_model.sv ----
// Execution unit and register file model on the far side of the issue pipeline
`default_nettype none
module fipi_far_model #(
  parameter int CW = 3
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic freg_we, // Register write pulse
  input wire logic freg_double, // Pair write
  input wire logic [4:0] freg_addr, // Register address
  input wire logic [63:0] freg_wdata, // Write data
  input wire logic [CW-1:0] queue_count, // Queue occupancy
  input wire logic fp_cond_valid, // Condition valid
  input wire logic unimpl_trap, // Trap raised
  input wire logic hold_exec, // Stall the execution unit
  input wire logic [1:0] cc_in, // Codes to report
  output logic [63:0] store_src, // Register read data
  output logic exec_done, // Queue head finished
  output logic cmp_done, // Compare result ready
  output logic [1:0] cmp_codes // Compare result codes
);
  logic [31:0] regs [32];
  logic [2:0] pace;
  logic [2:0] low_cnt;
  // Pair read: even register high, odd low
  assign store_src = {regs[freg_addr], regs[freg_addr | 5'h1]};
  // Writes land, queue head retires every fourth cycle, compare answers late
  always @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) regs[i] <= 32'h0f0f0000 + 32'(i);
      pace <= 3'h0;
      low_cnt <= 3'h0;
      exec_done <= 1'b0;
      cmp_done <= 1'b0;
    end else begin
      if (freg_we && freg_double) begin
        regs[freg_addr] <= freg_wdata[63:32];
        regs[freg_addr | 5'h1] <= freg_wdata[31:0];
      end else if (freg_we) regs[freg_addr] <= freg_wdata[31:0];
      pace <= pace + 3'h1;
      exec_done <= (queue_count != '0) && !hold_exec && (pace[1:0] == 2'h0);
      low_cnt <= fp_cond_valid ? 3'h0 : (low_cnt == 3'h7 ? low_cnt : low_cnt + 3'h1);
      cmp_done <= (low_cnt == 3'h3) && !unimpl_trap;
      cmp_codes <= cc_in;
    end
  end
endmodule : fipi_far_model
`default_nettype wire

// ---- verification/tb_fipi_core.sv ----
// Self-checking bench for the issue pipeline interface
`default_nettype none
module tb_fipi_core;
  timeunit 1ns;
  timeprecision 1ps;
  import fipi_pkg::*;
  localparam int QD = 4;
  localparam int CWB = $clog2(QD + 1);
  logic clock, sys_rst, hold_exec, exec_done, cmp_done, data_oe, fpu_stall_n, fp_cond_valid, unimpl_trap;
  logic issue_valid, freg_we, freg_double, iss_skip, st_skip, cv_prev;
  logic [1:0] cmp_codes, fp_cond_codes, cc_in, cc_prev;
  logic [4:0] freg_addr;
  logic [31:0] data_out, fp_status, w, hi, lo, pc, st_exp;
  logic [63:0] store_src, freg_wdata;
  logic [CWB-1:0] queue_count;
  fipi_entry_type issue_entry;
  fipi_pins_type pin;
  logic [69:0] exp_we[$];
  logic [63:0] exp_iss[$];
  logic [31:0] exp_st[$];
  logic [1:0] exp_cc[$];
  int n_errors, n_tests, seed, oe_cnt, cv_low;
  fipi_core #(.QDEPTH(QD)) uut (.clock(clock), .sys_rst(sys_rst), .addr_bus(pin.addr), .data_in(pin.data),
    .data_out(data_out), .data_oe(data_oe), .instr_fetch_flag(pin.fetch), .mem_stall_a_n(pin.stall_a_n),
    .mem_stall_b_n(pin.stall_b_n), .bus_stall_n(pin.stall_bus_n), .cp_stall_n(pin.stall_cp_n),
    .cp_cond_valid(pin.ccv), .mem_data_strobe_n(pin.strobe_n), .pipeline_abort(pin.abort),
    .launch_slot_one(pin.slot1), .launch_slot_two(pin.slot2), .store_src(store_src), .exec_done(exec_done),
    .cmp_done(cmp_done), .cmp_codes(cmp_codes), .fpu_stall_n(fpu_stall_n), .fp_cond_valid(fp_cond_valid),
    .fp_cond_codes(fp_cond_codes), .unimpl_trap(unimpl_trap), .issue_entry(issue_entry),
    .issue_valid(issue_valid), .queue_count(queue_count), .freg_we(freg_we), .freg_double(freg_double),
    .freg_addr(freg_addr), .freg_wdata(freg_wdata), .fp_status(fp_status));
  fipi_far_model #(.CW(CWB)) far (.clock(clock), .sys_rst(sys_rst), .freg_we(freg_we), .freg_double(freg_double),
    .freg_addr(freg_addr), .freg_wdata(freg_wdata), .queue_count(queue_count), .fp_cond_valid(fp_cond_valid),
    .unimpl_trap(unimpl_trap), .hold_exec(hold_exec), .cc_in(cc_in), .store_src(store_src),
    .exec_done(exec_done), .cmp_done(cmp_done), .cmp_codes(cmp_codes));
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(string nm, logic [69:0] e, logic [69:0] s);
    n_tests++;
    if (e !== s) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  function automatic logic [31:0] mk(logic [1:0] op, logic [4:0] rd, logic [5:0] op3, logic [18:0] rest);
    return {op, rd, op3, rest};
  endfunction : mk
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // Address one cycle, then word with the fetch flag
  task automatic fetch(logic [31:0] word);
    pc = pc + 32'h8;
    @(posedge clock);
    pin.addr <= pc;
    @(posedge clock);
    pin.data <= word;
    pin.fetch <= 1'b1;
    pin.addr <= ~pc;
    @(posedge clock);
    pin.fetch <= 1'b0;
    pin.data <= ~word;
  endtask : fetch
  // One strobe only, never both; bus words land in W and WH1
  task automatic launch(logic two, logic [31:0] d_hi, logic [31:0] d_lo, logic ab);
    @(posedge clock);
    if (two) pin.slot2 <= 1'b1;
    else pin.slot1 <= 1'b1;
    @(posedge clock);
    pin.slot1 <= 1'b0;
    pin.slot2 <= 1'b0;
    @(posedge clock);
    pin.data <= d_hi;
    pin.abort <= ab;
    @(posedge clock);
    pin.data <= d_lo;
    pin.abort <= 1'b0;
    @(posedge clock);
    pin.data <= ~d_lo;
    tick(14);
  endtask : launch
  task automatic hold(int k, logic on);
    case (k)
      0: pin.stall_a_n <= !on;
      1: pin.stall_b_n <= !on;
      2: pin.stall_bus_n <= !on;
      3: pin.stall_cp_n <= !on;
      4: pin.ccv <= !on;
      default: pin.abort <= on;
    endcase
  endtask : hold
  // Output watcher: each result takes the oldest note
  always @(posedge clock) begin
    if (!sys_rst) begin
      if (freg_we === 1'b1) begin
        if (exp_we.size() == 0) check("extra freg_we", '0, '1);
        else check("freg write", exp_we.pop_front(),
          {freg_double, freg_addr, freg_double ? freg_wdata : {32'h0, freg_wdata[31:0]}});
      end
      if (data_oe === 1'b1) begin
        oe_cnt++;
        if (!st_skip && exp_st.size() == 0) check("extra data_oe", '0, '1);
        else if (!st_skip) check("store word", exp_st.pop_front(), data_out);
      end
      if (issue_valid === 1'b1 && !iss_skip) begin
        if (exp_iss.size() == 0) check("extra issue", '0, '1);
        else check("issue entry", exp_iss.pop_front(), issue_entry);
      end
      if (fp_cond_valid !== 1'b1) cv_low++;
      if (fp_cond_valid === 1'b1 && cv_prev === 1'b0 && exp_cc.size() > 0)
        check("cond codes", exp_cc.pop_front(), cc_prev);
    end
    cv_prev <= fp_cond_valid;
    cc_prev <= fp_cond_codes;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    seed = 32'h4c96eb3d;
    pc = 32'h1000;
    pin = '0;
    {pin.stall_a_n, pin.stall_b_n, pin.stall_bus_n, pin.stall_cp_n, pin.ccv, pin.strobe_n} = 6'h3f;
    {hold_exec, iss_skip, st_skip, cc_in} = '0;
    sys_rst = 1'b1;
    tick(6);
    sys_rst <= 1'b0;
    tick(3);
    // Single load, double load, store of the pair back
    w = $random(seed);
    hi = $random(seed);
    lo = $random(seed);
    fetch(mk(2'h3, 5'd3, 6'h20, 19'h0));
    exp_we.push_back({1'b0, 5'd3, 32'h0, w});
    launch(1'b0, w, ~w, 1'b0);
    fetch(mk(2'h3, 5'd4, 6'h23, 19'h0));
    exp_we.push_back({1'b1, 5'd4, hi, lo});
    launch(1'b0, hi, lo, 1'b0);
    // Aborted load must leave the pair as it was
    fetch(mk(2'h3, 5'd4, 6'h23, 19'h0));
    launch(1'b0, ~hi, ~lo, 1'b1);
    fetch(mk(2'h3, 5'd4, 6'h27, 19'h0));
    exp_st.push_back(hi);
    exp_st.push_back(lo);
    launch(1'b0, 32'h0, 32'h0, 1'b0);
    // Single store of the word loaded first
    exp_st.push_back(w);
    fetch(mk(2'h3, 5'd3, 6'h24, 19'h0));
    launch(1'b0, 32'h0, 32'h0, 1'b0);
    // Aborted store releases the bus at once
    st_skip = 1'b1;
    oe_cnt = 0;
    fetch(mk(2'h3, 5'd4, 6'h27, 19'h0));
    launch(1'b0, 32'h0, 32'h0, 1'b1);
    check("oe cycles after abort", 70'(oe_cnt <= 1), 70'(1));
    st_skip = 1'b0;
    // Status load then status store
    st_exp = $random(seed);
    fetch(mk(2'h3, 5'd0, 6'h21, 19'h0));
    launch(1'b0, st_exp, 32'h0, 1'b0);
    check("status after load", st_exp, fp_status);
    fetch(mk(2'h3, 5'd0, 6'h25, 19'h0));
    exp_st.push_back(st_exp);
    launch(1'b0, 32'h0, 32'h0, 1'b0);
    // Fill the queue with the execution unit stalled
    hold_exec <= 1'b1;
    for (int i = 0; i <= QD; i++) begin
      // Queue store reads the head pair while the queue is full and idle
      if (i == QD) begin
        exp_st.push_back(hi);
        exp_st.push_back(lo);
        fetch(mk(2'h3, 5'd0, 6'h26, 19'h0));
        launch(1'b0, 32'h0, 32'h0, 1'b0);
      end
      w = mk(2'h2, 5'($random(seed)), 6'h34, 19'($random(seed)));
      fetch(w);
      exp_iss.push_back({pc, w});
      if (i == 0) {hi, lo} = {pc, w};
      launch(1'b0, 32'h0, 32'h0, 1'b0);
    end
    check("stall when full", 70'(0), 70'(fpu_stall_n));
    check("queue count full", 70'(QD), 70'(queue_count));
    hold_exec <= 1'b0;
    pin.stall_b_n <= 1'b0;
    tick(60);
    check("queue drained under stall", 70'(0), 70'(queue_count));
    check("stall released", 70'(1), 70'(fpu_stall_n));
    pin.stall_b_n <= 1'b1;
    // Aborted operation never reaches the queue
    fetch(mk(2'h2, 5'd7, 6'h34, 19'h1));
    launch(1'b0, 32'h0, 32'h0, 1'b1);
    check("queue after abort", 70'(0), 70'(queue_count));
    // Launches refused under every hold and under abort
    w = mk(2'h2, 5'd9, 6'h34, 19'h2);
    fetch(w);
    for (int k = 0; k < 6; k++) begin
      hold(k, 1'b1);
      launch(1'b0, 32'h0, 32'h0, 1'b0);
      hold(k, 1'b0);
    end
    exp_iss.push_back({pc, w});
    launch(1'b0, 32'h0, 32'h0, 1'b0);
    // Older entry through the second strobe
    hi = mk(2'h2, 5'd1, 6'h34, 19'h3);
    fetch(hi);
    exp_iss.push_back({pc, hi});
    fetch(mk(2'h2, 5'd2, 6'h34, 19'h4));
    launch(1'b1, 32'h0, 32'h0, 1'b0);
    // Cache miss: word replaced under the strobe, then a strobe without fetch
    w = mk(2'h2, 5'd5, 6'h34, 19'($random(seed)));
    pc = pc + 32'h8;
    @(posedge clock);
    pin.addr <= pc;
    @(posedge clock);
    pin.data <= ~w;
    pin.fetch <= 1'b1;
    @(posedge clock);
    pin.fetch <= 1'b0;
    pin.stall_a_n <= 1'b0;
    tick(2);
    pin.strobe_n <= 1'b0;
    pin.data <= w;
    @(posedge clock);
    pin.strobe_n <= 1'b1;
    pin.data <= 32'h0;
    @(posedge clock);
    pin.stall_a_n <= 1'b1;
    tick(2);
    pin.stall_bus_n <= 1'b0;
    tick(2);
    pin.strobe_n <= 1'b0;
    pin.data <= 32'hdead0001;
    @(posedge clock);
    pin.strobe_n <= 1'b1;
    pin.stall_bus_n <= 1'b1;
    exp_iss.push_back({pc, w});
    launch(1'b0, 32'h0, 32'h0, 1'b0);
    // Compares for every code value
    for (int c = 0; c < 4; c++) begin
      cc_in <= 2'(c);
      st_exp[11:10] = 2'(c);
      cv_low = 0;
      w = mk(2'h2, 5'd0, 6'h35, {5'h0, 5'h05, 4'h1, 5'(c)});
      fetch(w);
      exp_iss.push_back({pc, w});
      exp_cc.push_back(2'(c));
      launch(1'b0, 32'h0, 32'h0, 1'b0);
      check("valid dropped", 70'(cv_low > 0), 70'(1));
    end
    check("status codes", st_exp, fp_status);
    // Aborted compare and unimplemented compare
    iss_skip = 1'b1;
    cv_low = 0;
    fetch(mk(2'h2, 5'd0, 6'h35, {5'h0, 5'h05, 4'h1, 5'h0}));
    launch(1'b0, 32'h0, 32'h0, 1'b1);
    check("valid back after abort", 70'(cv_low <= 2), 70'(1));
    check("status kept", st_exp, fp_status);
    fetch(mk(2'h2, 5'd0, 6'h35, {5'h0, 5'h05, 4'h3, 5'h0}));
    launch(1'b0, 32'h0, 32'h0, 1'b0);
    check("trap raised", 70'(1), 70'({unimpl_trap, fp_cond_valid} == 2'b10));
    pin.abort <= 1'b1;
    @(posedge clock);
    pin.abort <= 1'b0;
    tick(8);
    check("trap cleared", 70'(2'b01), 70'({unimpl_trap, fp_cond_valid}));
    check("notes left", 70'(0), 70'(exp_we.size() + exp_iss.size() + exp_st.size() + exp_cc.size()));
    end_sim();
  end
endmodule : tb_fipi_core
`default_nettype wire
